/* common/pec_pkg.sv */
/*
 * pec_pkg: register map, field positions, reset values and carrier types
 * for the power-management event latch, interrupt mask and system control block.
 * Assumes a byte-wide register port and one 125 MHz clock with a synchronous reset.
 */
package pec_pkg;

   // ==========================================================================
   // register map
   localparam int ADDR_W = 9;
   localparam logic [8:0] OFS_EVT_PRIMARY = 9'h006;
   localparam logic [8:0] OFS_EVT_SUPPLY = 9'h007;
   localparam logic [8:0] OFS_EVT_INPUTS = 9'h008;
   localparam logic [8:0] OFS_MSK_PRIMARY = 9'h00a;
   localparam logic [8:0] OFS_MSK_SUPPLY = 9'h00b;
   localparam logic [8:0] OFS_MSK_INPUTS = 9'h00c;
   localparam logic [8:0] OFS_DOMAIN_CTL = 9'h00e;
   localparam logic [8:0] OFS_BEHAV_CTL = 9'h00f;

   // ==========================================================================
   // field positions
   localparam int EA_SUM_INPUTS = 6;
   localparam int EA_SUM_SUPPLY = 5;
   localparam int EA_SEQ_DONE = 4;
   localparam int EA_DOG_WARN = 3;
   localparam int EA_POWER_KEY = 0;
   localparam int EB_SUPPLY_WARN = 7;
   localparam int EB_RAMP_DONE = 5;
   localparam int EB_REG_OVERCUR = 3;
   localparam int EB_TEMP_WARN = 1;
   localparam int EC_INPUT_LO = 0;
   localparam int NUM_INPUTS = 5;
   localparam int NUM_DOMAINS = 3;
   localparam int CA_TARGET_LO = 0;
   localparam int CA_STANDBY = 3;
   localparam int CA_WMASK_LO = 4;
   localparam int CB_SOFT_LAUNCH = 7;
   localparam int CB_LIMIT_LO = 5;
   localparam int CB_KEY_LOCK = 4;
   localparam int CB_RST_MODE = 3;
   localparam int CB_FREEZE_EN = 2;
   localparam int CB_DOG_PD = 1;

   // bits that exist in each register; the rest read as zero, except bits 6 and 5 of the primary event register, which read the summaries
   localparam logic [7:0] IMPL_EVT_PRIMARY = 8'h19;
   localparam logic [7:0] IMPL_EVT_SUPPLY = 8'haa;
   localparam logic [7:0] IMPL_EVT_INPUTS = 8'h1f;
   localparam logic [7:0] IMPL_DOMAIN_CTL = 8'h7f;
   localparam logic [7:0] IMPL_BEHAV_CTL = 8'hfe;

   // ==========================================================================
   // reset values
   localparam logic [7:0] RST_EVT = 8'h00;
   localparam logic [7:0] RST_MSK = 8'h00;
   localparam logic [7:0] RST_DOMAIN_CTL = 8'h00;
   localparam logic [7:0] RST_BEHAV_CTL = 8'h00;
   // pin order: 0 power key (low active), 1..5 inputs, 6 system enable
   localparam int NUM_PINS = 7;
   localparam logic [6:0] RST_PINS = 7'h01;

   // ==========================================================================
   // carriers
   typedef struct packed {
      logic seq_done;       // pulse: sequencer at final position
      logic dog_warn;       // pulse: watchdog timeout warning
      logic supply_low;     // level: system supply at or below upper threshold
      logic ramp_done;      // pulse: all dynamic ramps finished
      logic reg_overcur;    // level: any linear regulator in current limit
      logic temp_warn;      // level: junction above warning threshold
      logic key_long;       // pulse: long key press detected
      logic dog_restart;    // pulse: restart caused by watchdog
      logic low_power;      // level: sequencer is in low_power_state
   } pec_evt_in_t;

   typedef struct packed {
      logic [2:0] domain_target;
      logic pd_req;
      logic pd_stop_partial;
      logic soft_launch;
      logic wake_block;
      logic key_lock;
      logic dog_run;
   } pec_ctl_out_t;

   typedef struct packed {
      logic [7:0] evt_a;
      logic [7:0] evt_b;
      logic [7:0] evt_c;
      logic [7:0] msk_a;
      logic [7:0] msk_b;
      logic [7:0] msk_c;
      logic [7:0] ctl_a;
      logic [7:0] ctl_b;
      logic [6:0] sync1;
      logic [6:0] sync2;
      logic [6:0] sync3;
      logic [6:0] stable;
      logic [2:0] restarts;
      logic [7:0] rdata;
      logic pd_req;
      logic rst_out_n;
   } pec_state_t;

endpackage

/* rtl/pec_event_ctrl.sv */
/*
 * pec_event_ctrl: event latching, summary, masking, interrupt request and
 * system control registers of the power-management device.
 * Assumes the two-wire slave decodes frames into single-cycle read and write
 * strobes on i_clk; sequencer, watchdog and converters sit outside.
 */

module pec_event_ctrl (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [pec_pkg::ADDR_W-1:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   input wire logic i_power_key_pin_n,
   input wire logic [pec_pkg::NUM_INPUTS-1:0] i_gpi_pin,
   input wire logic i_sys_enable_input,
   input wire pec_pkg::pec_evt_in_t i_evt,
   output pec_pkg::pec_ctl_out_t o_ctl,
   output logic o_reset_output_pin_n,
   output logic o_irq
);

   // ==========================================================================
   // register read decode
   function automatic logic [7:0] read_reg(input logic [pec_pkg::ADDR_W-1:0] a,
                                           input pec_pkg::pec_state_t st);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         pec_pkg::OFS_EVT_PRIMARY: begin
            v = st.evt_a & pec_pkg::IMPL_EVT_PRIMARY;
            v[pec_pkg::EA_SUM_INPUTS] = |st.evt_c;
            v[pec_pkg::EA_SUM_SUPPLY] = |st.evt_b;
         end
         pec_pkg::OFS_EVT_SUPPLY: v = st.evt_b;
         pec_pkg::OFS_EVT_INPUTS: v = st.evt_c;
         pec_pkg::OFS_MSK_PRIMARY: v = st.msk_a;
         pec_pkg::OFS_MSK_SUPPLY: v = st.msk_b;
         pec_pkg::OFS_MSK_INPUTS: v = st.msk_c;
         pec_pkg::OFS_DOMAIN_CTL: v = st.ctl_a;
         pec_pkg::OFS_BEHAV_CTL: v = st.ctl_b;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   function automatic logic is_wr(input logic wr,
                                  input logic [pec_pkg::ADDR_W-1:0] a,
                                  input logic [pec_pkg::ADDR_W-1:0] ofs);
      return wr && (a == ofs);
   endfunction

   localparam pec_pkg::pec_state_t STATE_RST = '{
      evt_a: pec_pkg::RST_EVT, evt_b: pec_pkg::RST_EVT, evt_c: pec_pkg::RST_EVT,
      msk_a: pec_pkg::RST_MSK, msk_b: pec_pkg::RST_MSK, msk_c: pec_pkg::RST_MSK,
      ctl_a: pec_pkg::RST_DOMAIN_CTL, ctl_b: pec_pkg::RST_BEHAV_CTL,
      sync1: pec_pkg::RST_PINS, sync2: pec_pkg::RST_PINS,
      sync3: pec_pkg::RST_PINS, stable: pec_pkg::RST_PINS,
      restarts: 3'h0, rdata: 8'h00, pd_req: 1'b0, rst_out_n: 1'b1};

   pec_pkg::pec_state_t s_r;
   pec_pkg::pec_state_t s_nxt;

   // ==========================================================================
   // next state
   always_comb begin
      logic key_press;
      logic sys_fall;
      logic tgt_cleared;
      logic [pec_pkg::NUM_INPUTS-1:0] gpi_rise;
      logic [7:0] wd;
      key_press = 1'b0;
      sys_fall = 1'b0;
      tgt_cleared = 1'b0;
      gpi_rise = '0;
      wd = i_reg_wdata;
      s_nxt = s_r;

      // three-stage pin synchroniser; a change counts once stages two and three agree
      s_nxt.sync1 = {i_sys_enable_input, i_gpi_pin, i_power_key_pin_n};
      s_nxt.sync2 = s_r.sync1;
      s_nxt.sync3 = s_r.sync2;
      for (int i = 0; i < pec_pkg::NUM_PINS; i++) begin
         if (s_r.sync2[i] == s_r.sync3[i]) begin
            s_nxt.stable[i] = s_r.sync3[i];
         end
      end
      key_press = s_r.stable[0] & ~s_nxt.stable[0];
      gpi_rise = s_nxt.stable[pec_pkg::NUM_INPUTS:1] & ~s_r.stable[pec_pkg::NUM_INPUTS:1];
      sys_fall = s_r.stable[pec_pkg::NUM_PINS-1] & ~s_nxt.stable[pec_pkg::NUM_PINS-1];

      // written ones clear first, then new events set, so a set wins
      if (is_wr(i_reg_wr, i_reg_addr, pec_pkg::OFS_EVT_PRIMARY)) begin
         s_nxt.evt_a = s_r.evt_a & ~wd;
      end
      if (is_wr(i_reg_wr, i_reg_addr, pec_pkg::OFS_EVT_SUPPLY)) begin
         s_nxt.evt_b = s_r.evt_b & ~wd;
      end
      if (is_wr(i_reg_wr, i_reg_addr, pec_pkg::OFS_EVT_INPUTS)) begin
         s_nxt.evt_c = s_r.evt_c & ~wd;
      end
      if (i_evt.seq_done) begin
         s_nxt.evt_a[pec_pkg::EA_SEQ_DONE] = 1'b1;
      end
      if (i_evt.dog_warn) begin
         s_nxt.evt_a[pec_pkg::EA_DOG_WARN] = 1'b1;
      end
      if (key_press) begin
         s_nxt.evt_a[pec_pkg::EA_POWER_KEY] = 1'b1;
      end
      // level sources re-latch for as long as the condition lasts
      if (i_evt.supply_low) begin
         s_nxt.evt_b[pec_pkg::EB_SUPPLY_WARN] = 1'b1;
      end
      if (i_evt.ramp_done) begin
         s_nxt.evt_b[pec_pkg::EB_RAMP_DONE] = 1'b1;
      end
      if (i_evt.reg_overcur) begin
         s_nxt.evt_b[pec_pkg::EB_REG_OVERCUR] = 1'b1;
      end
      if (i_evt.temp_warn) begin
         s_nxt.evt_b[pec_pkg::EB_TEMP_WARN] = 1'b1;
      end
      for (int i = 0; i < pec_pkg::NUM_INPUTS; i++) begin
         if (gpi_rise[i]) begin
            s_nxt.evt_c[pec_pkg::EC_INPUT_LO + i] = 1'b1;
         end
      end

      // masks only gate the request; latching carries on underneath
      if (is_wr(i_reg_wr, i_reg_addr, pec_pkg::OFS_MSK_PRIMARY)) begin
         s_nxt.msk_a = wd & pec_pkg::IMPL_EVT_PRIMARY;
      end
      if (is_wr(i_reg_wr, i_reg_addr, pec_pkg::OFS_MSK_SUPPLY)) begin
         s_nxt.msk_b = wd & pec_pkg::IMPL_EVT_SUPPLY;
      end
      if (is_wr(i_reg_wr, i_reg_addr, pec_pkg::OFS_MSK_INPUTS)) begin
         s_nxt.msk_c = wd & pec_pkg::IMPL_EVT_INPUTS;
      end

      // a target bit moves only when the same write carries its mask bit
      if (is_wr(i_reg_wr, i_reg_addr, pec_pkg::OFS_DOMAIN_CTL)) begin
         s_nxt.ctl_a[pec_pkg::CA_STANDBY] = wd[pec_pkg::CA_STANDBY];
         for (int i = 0; i < pec_pkg::NUM_DOMAINS; i++) begin
            s_nxt.ctl_a[pec_pkg::CA_WMASK_LO + i] = wd[pec_pkg::CA_WMASK_LO + i];
            if (wd[pec_pkg::CA_WMASK_LO + i]) begin
               s_nxt.ctl_a[pec_pkg::CA_TARGET_LO + i] = wd[pec_pkg::CA_TARGET_LO + i];
            end
         end
      end
      if (is_wr(i_reg_wr, i_reg_addr, pec_pkg::OFS_BEHAV_CTL)) begin
         s_nxt.ctl_b = wd & pec_pkg::IMPL_BEHAV_CTL;
      end

      tgt_cleared = s_r.ctl_a[pec_pkg::CA_TARGET_LO] & ~s_nxt.ctl_a[pec_pkg::CA_TARGET_LO];
      s_nxt.pd_req = tgt_cleared | sys_fall | i_evt.key_long;

      // saturating counter so a long run of restarts cannot wrap back below the limit
      if (!s_r.ctl_b[pec_pkg::CB_FREEZE_EN]) begin
         s_nxt.restarts = 3'h0;
      end else if (i_evt.dog_restart && (s_r.restarts != 3'h7)) begin
         s_nxt.restarts = s_r.restarts + 3'h1;
      end

      s_nxt.rst_out_n = ~(s_r.ctl_b[pec_pkg::CB_RST_MODE] & i_evt.low_power);

      if (i_reg_rd) begin
         s_nxt.rdata = read_reg(i_reg_addr, s_r);
      end

      if (i_srst) begin
         s_nxt = STATE_RST;
      end
   end

   always_ff @(posedge i_clk) begin
      s_r <= s_nxt;
   end

   // ==========================================================================
   // outputs
   logic [1:0] limit;
   assign limit = s_r.ctl_b[pec_pkg::CB_LIMIT_LO +: 2];

   assign o_reg_rdata = s_r.rdata;
   assign o_irq = |(s_r.evt_a & ~s_r.msk_a & pec_pkg::IMPL_EVT_PRIMARY)
                | |(s_r.evt_b & ~s_r.msk_b & pec_pkg::IMPL_EVT_SUPPLY)
                | |(s_r.evt_c & ~s_r.msk_c & pec_pkg::IMPL_EVT_INPUTS);
   assign o_ctl.domain_target = s_r.ctl_a[pec_pkg::CA_TARGET_LO +: 3];
   assign o_ctl.pd_req = s_r.pd_req;
   assign o_ctl.pd_stop_partial = s_r.ctl_a[pec_pkg::CA_STANDBY];
   assign o_ctl.soft_launch = s_r.ctl_b[pec_pkg::CB_SOFT_LAUNCH];
   assign o_ctl.wake_block = s_r.ctl_b[pec_pkg::CB_FREEZE_EN]
                           && (s_r.restarts >= {1'b0, limit});
   assign o_ctl.key_lock = s_r.ctl_b[pec_pkg::CB_KEY_LOCK];
   // watchdog stops only inside low_power_state, and only when not kept on
   assign o_ctl.dog_run = ~i_evt.low_power | s_r.ctl_b[pec_pkg::CB_DOG_PD];
   assign o_reset_output_pin_n = s_r.rst_out_n;

   // ==========================================================================
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   sum_inputs_a: assert property (
      (i_reg_rd && i_reg_addr == pec_pkg::OFS_EVT_PRIMARY)
         |=> o_reg_rdata[pec_pkg::EA_SUM_INPUTS] == (|$past(s_r.evt_c)))
      else $error("input summary bit wrong");
   clear_supply_a: assert property (
      (i_reg_wr && i_reg_addr == pec_pkg::OFS_EVT_SUPPLY
         && i_reg_wdata[pec_pkg::EB_RAMP_DONE] && !i_evt.ramp_done)
         |=> !s_r.evt_b[pec_pkg::EB_RAMP_DONE])
      else $error("written one did not clear flag");
   flag_sticky_a: assert property (
      (s_r.evt_a[pec_pkg::EA_DOG_WARN] && !(i_reg_wr && i_reg_addr == pec_pkg::OFS_EVT_PRIMARY))
         |=> s_r.evt_a[pec_pkg::EA_DOG_WARN])
      else $error("flag dropped without clear");
   seq_latch_a: assert property (
      i_evt.seq_done |=> s_r.evt_a[pec_pkg::EA_SEQ_DONE] ##1 o_irq || s_r.msk_a != 8'h00
         || !s_r.evt_a[pec_pkg::EA_SEQ_DONE])
      else $error("sequencer event not latched");
   supply_latch_a: assert property (
      i_evt.supply_low |=> s_r.evt_b[pec_pkg::EB_SUPPLY_WARN])
      else $error("supply warning not latched");
   temp_irq_a: assert property (
      (i_evt.temp_warn && !s_r.msk_b[pec_pkg::EB_TEMP_WARN]
         && !(i_reg_wr && i_reg_addr == pec_pkg::OFS_MSK_SUPPLY)) |=> o_irq)
      else $error("unmasked event gave no interrupt");
   target_masked_a: assert property (
      (i_reg_wr && i_reg_addr == pec_pkg::OFS_DOMAIN_CTL && !i_reg_wdata[pec_pkg::CA_WMASK_LO])
         |=> $stable(o_ctl.domain_target[0]))
      else $error("target changed without write mask");
   pd_on_clear_a: assert property (
      (i_reg_wr && i_reg_addr == pec_pkg::OFS_DOMAIN_CTL && s_r.ctl_a[pec_pkg::CA_TARGET_LO]
         && i_reg_wdata[pec_pkg::CA_WMASK_LO] && !i_reg_wdata[pec_pkg::CA_TARGET_LO])
         |=> o_ctl.pd_req ##1 !o_ctl.pd_req || i_evt.key_long || $past(i_evt.key_long))
      else $error("no power-down on target clear");
   reset_pin_a: assert property (
      (!s_r.ctl_b[pec_pkg::CB_RST_MODE] && !(i_reg_wr && i_reg_addr == pec_pkg::OFS_BEHAV_CTL))
         |=> o_reset_output_pin_n)
      else $error("reset pin asserted in keep mode");
   dog_stop_a: assert property (
      (i_evt.low_power && !s_r.ctl_b[pec_pkg::CB_DOG_PD]) |-> !o_ctl.dog_run)
      else $error("watchdog runs in low_power_state");
   freeze_cnt_a: assert property (
      (s_r.ctl_b[pec_pkg::CB_FREEZE_EN] && i_evt.dog_restart && s_r.restarts < 3'h7
         && !(i_reg_wr && i_reg_addr == pec_pkg::OFS_BEHAV_CTL))
         |=> s_r.restarts == $past(s_r.restarts) + 3'h1)
      else $error("restart not counted");
   sum_supply_a: assert property (
      (i_reg_rd && i_reg_addr == pec_pkg::OFS_EVT_PRIMARY)
         |=> o_reg_rdata[pec_pkg::EA_SUM_SUPPLY] == (|$past(s_r.evt_b)))
      else $error("supply summary bit wrong");
   dog_latch_a: assert property (
      i_evt.dog_warn |=> s_r.evt_a[pec_pkg::EA_DOG_WARN])
      else $error("watchdog warning not latched");
   key_latch_a: assert property (
      (s_r.stable[0] && !s_nxt.stable[0])
         |=> s_r.evt_a[pec_pkg::EA_POWER_KEY])
      else $error("key press not latched");
   ramp_latch_a: assert property (
      i_evt.ramp_done |=> s_r.evt_b[pec_pkg::EB_RAMP_DONE])
      else $error("ramp done not latched");
   overcur_latch_a: assert property (
      i_evt.reg_overcur |=> s_r.evt_b[pec_pkg::EB_REG_OVERCUR])
      else $error("over-current not latched");
   input_latch_a: assert property (
      (s_nxt.stable[1] && !s_r.stable[1])
         |=> s_r.evt_c[pec_pkg::EC_INPUT_LO])
      else $error("input rise not latched");
   mask_latch_a: assert property (
      (i_evt.temp_warn && s_r.msk_b[pec_pkg::EB_TEMP_WARN])
         |=> s_r.evt_b[pec_pkg::EB_TEMP_WARN])
      else $error("masked event did not latch");
   soft_launch_a: assert property (
      (i_reg_wr && i_reg_addr == pec_pkg::OFS_BEHAV_CTL && i_reg_wdata[pec_pkg::CB_SOFT_LAUNCH])
         |=> o_ctl.soft_launch)
      else $error("soft launch not enabled");
   key_lock_a: assert property (
      (i_reg_wr && i_reg_addr == pec_pkg::OFS_BEHAV_CTL && i_reg_wdata[pec_pkg::CB_KEY_LOCK])
         |=> o_ctl.key_lock)
      else $error("key lock not set");
   wake_free_a: assert property (
      !s_r.ctl_b[pec_pkg::CB_FREEZE_EN] |-> !o_ctl.wake_block)
      else $error("wakeups blocked without freeze");
   dog_keep_a: assert property (
      s_r.ctl_b[pec_pkg::CB_DOG_PD] |-> o_ctl.dog_run)
      else $error("watchdog stopped though kept on");
   pd_pin_a: assert property (
      (s_r.stable[pec_pkg::NUM_PINS-1] && !s_nxt.stable[pec_pkg::NUM_PINS-1])
         |=> o_ctl.pd_req)
      else $error("no power-down on enable release");
   pd_key_a: assert property (
      i_evt.key_long |=> o_ctl.pd_req)
      else $error("no power-down on long key press");
   rst_assert_a: assert property (
      (s_r.ctl_b[pec_pkg::CB_RST_MODE] && i_evt.low_power
         && !(i_reg_wr && i_reg_addr == pec_pkg::OFS_BEHAV_CTL)) |=> !o_reset_output_pin_n)
      else $error("reset pin not asserted in low_power_state");

endmodule

/* testbench/pec_host_model.sv */
/*
 * pec_host_model: host processor on the register port, byte reads and writes.
 * Assumes the device takes a strobe at a rising edge of i_clk and answers a cycle later.
 */
module pec_host_model (
   input wire logic i_clk,
   output logic o_wr,
   output logic o_rd,
   output logic [pec_pkg::ADDR_W-1:0] o_addr,
   output logic [7:0] o_wdata,
   input wire logic [7:0] i_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================================
   // idle bus
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 9'h000;
      o_wdata = 8'h00;
   end

   // ==========================================================================
   // transfers; a released bus shows the inverse so stale values never match
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
      // return one edge later so callers see the registers the write just updated
      @(posedge i_clk);
   endtask

   task automatic rd(input logic [8:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_clk);
      o_rd <= 1'b0;
      o_addr <= ~a;
      // read data is registered at the strobe edge and holds until the next read
      @(posedge i_clk);
      d = i_rdata;
   endtask

   // clearing events means writing back exactly what was read
   task automatic rd_clr(input logic [8:0] a, output logic [7:0] d);
      rd(a, d);
      wr(a, d);
   endtask
endmodule

/* testbench/tb_pec_event_ctrl.sv */
/*
 * tb_pec_event_ctrl: self-checking bench for the event, mask and control block.
 * Assumes pec_pkg and pec_host_model are compiled first; one 125 MHz clock.
 */
`define CHK(nm, ex, got) \
   begin \
      samples_checked++; \
      if ((got) !== (ex)) begin \
         errors++; \
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
      end \
   end

module tb_pec_event_ctrl;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic srst = 1'b1;
   logic key_n = 1'b1;
   logic [4:0] gpi = 5'h00;
   logic sys_enable_input = 1'b1;
   pec_pkg::pec_evt_in_t evt = '0;
   pec_pkg::pec_ctl_out_t ctl;
   logic wr, rd, rst_n, irq;
   logic [8:0] addr;
   logic [7:0] wdata, rdata, d;
   int errors = 0;
   int samples_checked = 0;
   int pd_cnt = 0;

   // ==========================================================================
   // clock, design, host
   initial begin
      forever #4 clk = ~clk;
   end

   pec_event_ctrl pec_event_ctrl_i (.i_clk(clk), .i_srst(srst), .i_reg_wr(wr),
      .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .i_power_key_pin_n(key_n), .i_gpi_pin(gpi), .i_sys_enable_input(sys_enable_input),
      .i_evt(evt), .o_ctl(ctl), .o_reset_output_pin_n(rst_n), .o_irq(irq));

   pec_host_model pec_host_model_i (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
      .o_wdata(wdata), .i_rdata(rdata));

   always @(posedge clk) begin
      if (ctl.pd_req === 1'b1) begin
         pd_cnt++;
      end
   end

   // ==========================================================================
   // helpers
   task automatic pulse(input pec_pkg::pec_evt_in_t v);
      @(posedge clk);
      v.low_power = evt.low_power;
      evt <= v;
      @(posedge clk);
      v = '0;
      v.low_power = evt.low_power;
      evt <= v;
   endtask

   task automatic rchk(input logic [8:0] a, input logic [7:0] ex, input string nm);
      pec_host_model_i.rd(a, d);
      `CHK(nm, ex, d)
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ==========================================================================
   // scenarios
   task automatic s_events(input logic [7:0] msk_b);
      pec_pkg::pec_evt_in_t v;
      v = '0;
      v.seq_done = 1'b1;
      v.dog_warn = 1'b1;
      v.ramp_done = 1'b1;
      v.supply_low = 1'b1;
      v.reg_overcur = 1'b1;
      v.temp_warn = 1'b1;
      pec_host_model_i.wr(pec_pkg::OFS_MSK_SUPPLY, msk_b);
      pec_host_model_i.wr(pec_pkg::OFS_MSK_PRIMARY, msk_b & 8'h19);
      pulse(v);
      rchk(pec_pkg::OFS_EVT_PRIMARY, 8'h38, "evt_primary");
      `CHK("irq", msk_b === 8'h00, irq)
      rchk(pec_pkg::OFS_EVT_SUPPLY, 8'haa, "evt_supply");
      pec_host_model_i.rd_clr(pec_pkg::OFS_EVT_SUPPLY, d);
      rchk(pec_pkg::OFS_EVT_SUPPLY, 8'h00, "evt_supply_clr");
      rchk(pec_pkg::OFS_EVT_PRIMARY, 8'h18, "sum_supply");
      pec_host_model_i.wr(pec_pkg::OFS_EVT_PRIMARY, 8'h08);
      rchk(pec_pkg::OFS_EVT_PRIMARY, 8'h10, "evt_one_clr");
      pec_host_model_i.rd_clr(pec_pkg::OFS_EVT_PRIMARY, d);
      `CHK("irq_clr", 1'b0, irq)
      pec_host_model_i.wr(pec_pkg::OFS_MSK_PRIMARY, 8'h00);
   endtask

   task automatic s_pins();
      gpi <= 5'h1f;
      repeat (8) @(posedge clk);
      rchk(pec_pkg::OFS_EVT_INPUTS, 8'h1f, "evt_inputs");
      key_n <= 1'b0;
      repeat (8) @(posedge clk);
      rchk(pec_pkg::OFS_EVT_PRIMARY, 8'h41, "key_and_sum");
      pec_host_model_i.wr(pec_pkg::OFS_MSK_INPUTS, 8'h1f);
      rchk(pec_pkg::OFS_MSK_INPUTS, 8'h1f, "msk_inputs");
      pec_host_model_i.rd_clr(pec_pkg::OFS_EVT_PRIMARY, d);
      `CHK("irq_inputs_masked", 1'b0, irq)
      key_n <= 1'b1;
      gpi <= 5'h00;
      pec_host_model_i.rd_clr(pec_pkg::OFS_EVT_INPUTS, d);
      repeat (8) @(posedge clk);
      rchk(pec_pkg::OFS_EVT_INPUTS, 8'h00, "inputs_fall");
      pec_host_model_i.wr(pec_pkg::OFS_MSK_INPUTS, 8'h00);
   endtask

   task automatic s_domain();
      pec_pkg::pec_evt_in_t v;
      v = '0;
      v.key_long = 1'b1;
      pec_host_model_i.wr(pec_pkg::OFS_DOMAIN_CTL, 8'h0f);
      rchk(pec_pkg::OFS_DOMAIN_CTL, 8'h08, "targets_masked");
      `CHK("stop_partial", 1'b1, ctl.pd_stop_partial)
      pec_host_model_i.wr(pec_pkg::OFS_DOMAIN_CTL, 8'h77);
      `CHK("targets", 3'h7, ctl.domain_target)
      pec_host_model_i.wr(pec_pkg::OFS_DOMAIN_CTL, 8'h10);
      repeat (4) @(posedge clk);
      rchk(pec_pkg::OFS_DOMAIN_CTL, 8'h16, "target0_only");
      `CHK("pd_by_write", 1, pd_cnt)
      sys_enable_input <= 1'b0;
      repeat (8) @(posedge clk);
      pulse(v);
      repeat (4) @(posedge clk);
      `CHK("pd_pin_key", 3, pd_cnt)
      `CHK("stop_full", 1'b0, ctl.pd_stop_partial)
   endtask

   task automatic s_behaviour();
      pec_pkg::pec_evt_in_t v;
      v = '0;
      v.dog_restart = 1'b1;
      pec_host_model_i.wr(pec_pkg::OFS_BEHAV_CTL, 8'hff);
      rchk(pec_pkg::OFS_BEHAV_CTL, 8'hfe, "behav_ctl");
      `CHK("soft_key", 2'b11, {ctl.soft_launch, ctl.key_lock})
      evt.low_power <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK("rst_pin_pd", 1'b0, rst_n)
      `CHK("dog_run_pd", 1'b1, ctl.dog_run)
      pec_host_model_i.wr(pec_pkg::OFS_BEHAV_CTL, 8'h24);
      repeat (3) @(posedge clk);
      `CHK("rst_pin_keep", 1'b1, rst_n)
      `CHK("dog_stop_pd", 1'b0, ctl.dog_run)
      `CHK("wake_ok", 1'b0, ctl.wake_block)
      pulse(v);
      @(posedge clk);
      `CHK("wake_block", 1'b1, ctl.wake_block)
      pec_host_model_i.wr(pec_pkg::OFS_BEHAV_CTL, 8'h00);
      `CHK("freeze_off", 2'b00, {ctl.wake_block, ctl.soft_launch})
      evt.low_power <= 1'b0;
      pec_host_model_i.wr(9'h009, 8'hff);
      rchk(9'h009, 8'h00, "unmapped");
   endtask

   // ==========================================================================
   // main sequence and watchdog
   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      rchk(pec_pkg::OFS_EVT_PRIMARY, pec_pkg::RST_EVT, "rst_evt");
      rchk(pec_pkg::OFS_MSK_SUPPLY, pec_pkg::RST_MSK, "rst_msk");
      rchk(pec_pkg::OFS_BEHAV_CTL, pec_pkg::RST_BEHAV_CTL, "rst_ctl");
      `CHK("rst_irq_pin", 2'b01, {irq, rst_n})
      s_events(8'h00);
      s_events(8'hff);
      s_pins();
      s_domain();
      s_behaviour();
      end_sim();
   end

   initial begin
      #100000;
      errors++;
      end_sim();
   end
endmodule
